// ### rtl/cbu_pkg.sv
// Constants for the branch unit: opcodes, field widths and test patterns.
// Assumes an 18-bit address space and 60-bit operand words.
package cbu_pkg;
    localparam int ADDR_W  = 18;
    localparam int WORD_W  = 60;
    localparam int OP_W    = 6;
    localparam int SIGN_B  = 59;
    localparam int EXP_W   = 12;
    localparam int HALF_W  = 30;
    // Opcodes of the branch group.
    localparam logic [OP_W-1:0] OP_CALL_LINK = 6'h01;
    localparam logic [OP_W-1:0] OP_IDX_JUMP  = 6'h02;
    localparam logic [OP_W-1:0] OP_WORD_TEST = 6'h03;
    localparam logic [OP_W-1:0] OP_SAME      = 6'h04;
    localparam logic [OP_W-1:0] OP_DIFFER    = 6'h05;
    localparam logic [OP_W-1:0] OP_AT_LEAST  = 6'h06;
    localparam logic [OP_W-1:0] OP_BELOW     = 6'h07;
    // Condition digit of the operand word tests.
    localparam logic [2:0] TST_NULL     = 3'h0;
    localparam logic [2:0] TST_NONNULL  = 3'h1;
    localparam logic [2:0] TST_CLEAR    = 3'h2;
    localparam logic [2:0] TST_SET      = 3'h3;
    localparam logic [2:0] TST_IN_SPAN  = 3'h4;
    localparam logic [2:0] TST_BEYOND   = 3'h5;
    localparam logic [2:0] TST_DEFINED  = 3'h6;
    localparam logic [2:0] TST_UNDEF    = 3'h7;
    // Upper 12-bit patterns: infinities and indefinites.
    localparam logic [EXP_W-1:0] PAT_PLUS_INF  = 12'h7ff;
    localparam logic [EXP_W-1:0] PAT_MINUS_INF = 12'h800;
    localparam logic [EXP_W-1:0] PAT_PLUS_IND  = 12'h3ff;
    localparam logic [EXP_W-1:0] PAT_MINUS_IND = 12'hc00;
    // Unconditional jump planted by the call-link jump: opcode 04 in the
    // six opcode bits, both register digits zero.
    localparam logic [11:0] PLANT_JUMP_OP = 12'h100;
    localparam logic [ADDR_W-1:0] ADDR_ONE = 18'h00001;
endpackage

// ### rtl/cbu_ones_add.sv
// Ones'-complement adder of 18-bit words with end-around carry.
// Assumes purely combinational use inside the branch unit.
`timescale 1ns/1ps
`default_nettype none
module cbu_ones_add
    import cbu_pkg::*;
(
    input  wire logic [ADDR_W-1:0] a,
    input  wire logic [ADDR_W-1:0] b,
    output logic      [ADDR_W-1:0] sum
);
    logic [ADDR_W:0] raw;
    always_comb begin
        raw = {1'b0, a} + {1'b0, b};
        sum = raw[ADDR_W-1:0] + {{(ADDR_W-1){1'b0}}, raw[ADDR_W]};
    end
endmodule
`default_nettype wire

// ### rtl/cbu_branch.sv
// Branch unit: evaluates jump instructions, gives the next address and
// invalidates the instruction stack. Issue logic presents one instruction
// per issue_vld pulse; register files supply operands on the same cycle.
//
// Contract
// - Call-link plants a jump to P+1 in word K's upper half, goes to K+1.
// - Call-link and indexed jumps fetch from memory and void the stack.
// - Indexed jump adds index i to K in ones' complement; i of 0 gives K.
// - Null tests count all zeros and all ones over 60 bits as zero.
// - Sign tests look only at bit 59, zero positive and one negative.
// - Span tests call upper patterns 3777 and 4000 octal out of range.
// - Definite tests call upper patterns 1777 and 6000 octal indefinite.
// - Opcodes 04 to 07 jump to K on equal, unequal, at least and below.
// - Plus zero is unequal to and above minus zero; plus beats minus.
// - At least and below test signs first, subtract only on like signs.
`timescale 1ns/1ps
`default_nettype none
module cbu_branch
    import cbu_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              sys_rst,
    input  wire logic              clk_en,
    input  wire logic              issue_vld,
    input  wire logic [OP_W-1:0]   issue_op,
    input  wire logic [2:0]        issue_i,
    input  wire logic [ADDR_W-1:0] target_field,
    input  wire logic [ADDR_W-1:0] cur_p,
    input  wire logic [ADDR_W-1:0] index_reg_first,
    input  wire logic [ADDR_W-1:0] index_reg_second,
    input  wire logic [WORD_W-1:0] operand_reg_tested,
    output logic                   next_vld,
    output logic      [ADDR_W-1:0] next_addr,
    output logic                   from_memory,
    output logic                   stack_void,
    output logic                   plant_we,
    output logic      [ADDR_W-1:0] plant_addr,
    output logic      [HALF_W-1:0] plant_data
);
    logic              next_vld_r, next_vld_nxt;
    logic [ADDR_W-1:0] next_addr_r, next_addr_nxt;
    logic              from_mem_r, from_mem_nxt;
    logic              void_r, void_nxt;
    logic              plant_we_r, plant_we_nxt;
    logic [ADDR_W-1:0] plant_addr_r, plant_addr_nxt;
    logic [HALF_W-1:0] plant_data_r, plant_data_nxt;
    logic [ADDR_W-1:0] idx_sum;
    logic [ADDR_W-1:0] diff;
    logic              cond;
    logic              is_branch_op;

    function automatic logic upper_is(input logic [WORD_W-1:0] w,
                                      input logic [EXP_W-1:0] p1,
                                      input logic [EXP_W-1:0] p2);
        logic [EXP_W-1:0] up;
        up = w[WORD_W-1 -: EXP_W];
        return (up == p1) || (up == p2);
    endfunction

    // Index plus K; the zero index register makes the sum K itself.
    cbu_ones_add u_add (
        .a   (index_reg_first),
        .b   (target_field),
        .sum (idx_sum)
    );

    always_comb begin
        logic zero_w;
        logic sa;
        logic sb;
        logic ge;
        ge = 1'b0;
        zero_w = (operand_reg_tested == '0) || (&operand_reg_tested);
        sa = index_reg_first[ADDR_W-1];
        sb = index_reg_second[ADDR_W-1];
        // Same-sign subtraction as done in the increment unit.
        diff = index_reg_first - index_reg_second;
        if (sa != sb) begin
            ge = !sa;
        end else begin
            ge = !diff[ADDR_W-1];
        end
        cond = 1'b0;
        is_branch_op = 1'b1;
        case (issue_op)
            OP_WORD_TEST: begin
                case (issue_i)
                    TST_NULL:    cond = zero_w;
                    TST_NONNULL: cond = !zero_w;
                    TST_CLEAR:   cond = !operand_reg_tested[SIGN_B];
                    TST_SET:     cond = operand_reg_tested[SIGN_B];
                    TST_IN_SPAN: cond = !upper_is(operand_reg_tested,
                        PAT_PLUS_INF, PAT_MINUS_INF);
                    TST_BEYOND:  cond = upper_is(operand_reg_tested,
                        PAT_PLUS_INF, PAT_MINUS_INF);
                    TST_DEFINED: cond = !upper_is(operand_reg_tested,
                        PAT_PLUS_IND, PAT_MINUS_IND);
                    default:     cond = upper_is(operand_reg_tested,
                        PAT_PLUS_IND, PAT_MINUS_IND);
                endcase
            end
            // Bitwise equality keeps the two zeros apart.
            OP_SAME:     cond = index_reg_first == index_reg_second;
            OP_DIFFER:   cond = index_reg_first != index_reg_second;
            OP_AT_LEAST: cond = ge;
            OP_BELOW:    cond = !ge;
            OP_CALL_LINK, OP_IDX_JUMP: cond = 1'b1;
            default:     is_branch_op = 1'b0;
        endcase
    end

    always_comb begin
        next_vld_nxt   = 1'b0;
        next_addr_nxt  = next_addr_r;
        from_mem_nxt   = 1'b0;
        void_nxt       = 1'b0;
        plant_we_nxt   = 1'b0;
        plant_addr_nxt = plant_addr_r;
        plant_data_nxt = plant_data_r;
        if (issue_vld && is_branch_op) begin
            next_vld_nxt = 1'b1;
            if (issue_op == OP_CALL_LINK) begin
                plant_we_nxt   = 1'b1;
                plant_addr_nxt = target_field;
                plant_data_nxt = {PLANT_JUMP_OP, cur_p + ADDR_ONE};
                next_addr_nxt  = target_field + ADDR_ONE;
                from_mem_nxt   = 1'b1;
                void_nxt       = 1'b1;
            end else if (issue_op == OP_IDX_JUMP) begin
                next_addr_nxt = idx_sum;
                from_mem_nxt  = 1'b1;
                void_nxt      = 1'b1;
            end else if (cond) begin
                next_addr_nxt = target_field;
            end else begin
                next_addr_nxt = cur_p + ADDR_ONE;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            next_vld_r   <= 1'b0;
            next_addr_r  <= '0;
            from_mem_r   <= 1'b0;
            void_r       <= 1'b0;
            plant_we_r   <= 1'b0;
            plant_addr_r <= '0;
            plant_data_r <= '0;
        end else if (clk_en) begin
            next_vld_r   <= next_vld_nxt;
            next_addr_r  <= next_addr_nxt;
            from_mem_r   <= from_mem_nxt;
            void_r       <= void_nxt;
            plant_we_r   <= plant_we_nxt;
            plant_addr_r <= plant_addr_nxt;
            plant_data_r <= plant_data_nxt;
        end
    end

    assign next_vld    = next_vld_r;
    assign next_addr   = next_addr_r;
    assign from_memory = from_mem_r;
    assign stack_void  = void_r;
    assign plant_we    = plant_we_r;
    assign plant_addr  = plant_addr_r;
    assign plant_data  = plant_data_r;

    call_plant_a: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        clk_en && issue_vld && issue_op == OP_CALL_LINK |=> plant_we &&
        plant_addr == $past(target_field) &&
        next_addr == $past(target_field) + ADDR_ONE &&
        plant_data[ADDR_W-1:0] == $past(cur_p) + ADDR_ONE)
        else $error("call link plant wrong");
    stack_void_a: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        stack_void |-> from_memory && next_vld)
        else $error("stack voided without memory fetch");
    idx_jump_a: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        clk_en && issue_vld && issue_op == OP_IDX_JUMP &&
        index_reg_first == '0
        |=> next_addr == $past(target_field) && stack_void)
        else $error("indexed jump with zero index wrong");
    null_test_a: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        clk_en && issue_vld && issue_op == OP_WORD_TEST &&
        issue_i == TST_NULL && &operand_reg_tested
        |=> next_addr == $past(target_field))
        else $error("all ones not taken as zero");
    sign_test_a: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        clk_en && issue_vld && issue_op == OP_WORD_TEST &&
        issue_i == TST_SET && !operand_reg_tested[SIGN_B]
        |=> next_addr == $past(cur_p) + ADDR_ONE)
        else $error("sign set taken on positive word");
    span_test_a: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        clk_en && issue_vld && issue_op == OP_WORD_TEST &&
        issue_i == TST_BEYOND &&
        operand_reg_tested[WORD_W-1 -: EXP_W] == PAT_MINUS_INF
        |=> next_addr == $past(target_field))
        else $error("minus infinity not out of range");
    undef_test_a: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        clk_en && issue_vld && issue_op == OP_WORD_TEST &&
        issue_i == TST_UNDEF &&
        operand_reg_tested[WORD_W-1 -: EXP_W] == PAT_MINUS_IND
        |=> next_addr == $past(target_field))
        else $error("minus indefinite not detected");
    zero_order_a: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        clk_en && issue_vld && issue_op == OP_AT_LEAST &&
        index_reg_first == '0 && index_reg_second == '1
        |=> next_addr == $past(target_field))
        else $error("positive zero not above negative zero");
    sign_first_a: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        clk_en && issue_vld && issue_op == OP_BELOW &&
        index_reg_first[ADDR_W-1] && !index_reg_second[ADDR_W-1]
        |=> next_addr == $past(target_field))
        else $error("negative not below positive");
    fail_seq_a: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        clk_en && issue_vld && issue_op == OP_DIFFER &&
        index_reg_first == index_reg_second
        |=> !stack_void && next_addr == $past(cur_p) + ADDR_ONE)
        else $error("failed test voided stack or skipped");
    same_taken_a: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        clk_en && issue_vld && issue_op == OP_SAME &&
        index_reg_first == index_reg_second
        |=> next_vld && next_addr == $past(target_field))
        else $error("equal compare not taken");
    differ_zero_a: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        clk_en && issue_vld && issue_op == OP_DIFFER &&
        index_reg_first == '0 && index_reg_second == '1
        |=> next_addr == $past(target_field))
        else $error("plus zero equal to minus zero");
    plus_above_a: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        clk_en && issue_vld && issue_op == OP_BELOW &&
        !index_reg_first[ADDR_W-1] && index_reg_second[ADDR_W-1]
        |=> next_addr == $past(cur_p) + ADDR_ONE)
        else $error("positive taken as below negative");
    like_sign_a: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        clk_en && issue_vld && issue_op == OP_AT_LEAST &&
        index_reg_first[ADDR_W-1] == index_reg_second[ADDR_W-1] &&
        $signed(index_reg_first) < $signed(index_reg_second)
        |=> next_addr == $past(cur_p) + ADDR_ONE)
        else $error("smaller like-signed value taken as at least");
    below_taken_a: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        clk_en && issue_vld && issue_op == OP_BELOW &&
        index_reg_first[ADDR_W-1] == index_reg_second[ADDR_W-1] &&
        $signed(index_reg_first) < $signed(index_reg_second)
        |=> next_vld && next_addr == $past(target_field))
        else $error("below compare not taken");
    nonnull_test_a: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        clk_en && issue_vld && issue_op == OP_WORD_TEST &&
        issue_i == TST_NONNULL && operand_reg_tested == '0
        |=> next_addr == $past(cur_p) + ADDR_ONE)
        else $error("zero word taken as nonnull");
    clear_test_a: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        clk_en && issue_vld && issue_op == OP_WORD_TEST &&
        issue_i == TST_CLEAR && !operand_reg_tested[SIGN_B]
        |=> next_addr == $past(target_field))
        else $error("sign clear not taken on positive word");
    in_span_a: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        clk_en && issue_vld && issue_op == OP_WORD_TEST &&
        issue_i == TST_IN_SPAN &&
        operand_reg_tested[WORD_W-1 -: EXP_W] == PAT_PLUS_INF
        |=> next_addr == $past(cur_p) + ADDR_ONE)
        else $error("plus infinity taken as in range");
    defined_test_a: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        clk_en && issue_vld && issue_op == OP_WORD_TEST &&
        issue_i == TST_DEFINED &&
        operand_reg_tested[WORD_W-1 -: EXP_W] == PAT_PLUS_IND
        |=> next_addr == $past(cur_p) + ADDR_ONE)
        else $error("plus indefinite taken as definite");
    idx_void_a: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        clk_en && issue_vld && issue_op == OP_IDX_JUMP
        |=> stack_void && from_memory && next_vld)
        else $error("indexed jump kept the stack");
    call_void_a: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        clk_en && issue_vld && issue_op == OP_CALL_LINK
        |=> stack_void && from_memory && next_vld)
        else $error("call link kept the stack");
    neg_zero_a: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        clk_en && issue_vld && issue_op == OP_IDX_JUMP &&
        index_reg_first == '1 && target_field != '0
        |=> next_addr == $past(target_field))
        else $error("minus zero index moved the target");
    cond_keep_a: assert property (@(posedge ref_clk)
        disable iff (sys_rst)
        clk_en && issue_vld && issue_op >= OP_WORD_TEST &&
        issue_op <= OP_BELOW
        |=> !stack_void && !from_memory && !plant_we)
        else $error("conditional jump voided stack or planted");
endmodule
`default_nettype wire

// ### tb/cbu_issue_model.sv
// Model of the issue logic and register files that feed the branch unit.
// Assumes the bench calls its tasks; fields change at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module cbu_issue_model
    import cbu_pkg::*;
(
    input  wire logic              ref_clk,
    output logic                   issue_vld,
    output logic      [OP_W-1:0]   issue_op,
    output logic      [2:0]        issue_i,
    output logic      [ADDR_W-1:0] target_field,
    output logic      [ADDR_W-1:0] cur_p,
    output logic      [ADDR_W-1:0] index_reg_first,
    output logic      [ADDR_W-1:0] index_reg_second,
    output logic      [WORD_W-1:0] operand_reg_tested
);
    initial begin
        {issue_vld, issue_op, issue_i, target_field, cur_p} = '0;
        {index_reg_first, index_reg_second, operand_reg_tested} = '0;
    end
    task automatic send(input logic [OP_W-1:0] op, input logic [2:0] i,
                        input logic [ADDR_W-1:0] k, p, bi, bj,
                        input logic [WORD_W-1:0] x, input logic use_zero);
        @(negedge ref_clk);
        issue_vld = 1'b1;
        issue_op = op;
        issue_i = i;
        target_field = k;
        cur_p = p;
        index_reg_first = bi;
        // The zero index register always reads as all zeros.
        index_reg_second = use_zero ? '0 : bj;
        operand_reg_tested = x;
    endtask
    task automatic idle();
        @(negedge ref_clk);
        issue_vld = 1'b0;
        // Released fields other than issue_i and cur_p flip so stale values never pass for fresh ones.
        issue_op = ~issue_op;
        target_field = ~target_field;
        index_reg_first = ~index_reg_first;
        index_reg_second = ~index_reg_second;
        operand_reg_tested = ~operand_reg_tested;
    endtask
endmodule
`default_nettype wire

// ### tb/test_cbu_branch.sv
// Self-checking bench of the branch unit, one task per scenario.
// Assumes the issue model in cbu_issue_model and fixed one-cycle answers.
`timescale 1ns/1ps
`default_nettype none
module test_cbu_branch;
    import cbu_pkg::*;
    logic              ref_clk, sys_rst, clk_en, issue_vld;
    logic              next_vld, from_memory, stack_void, plant_we;
    logic [OP_W-1:0]   issue_op;
    logic [2:0]        issue_i;
    logic [ADDR_W-1:0] target_field, cur_p, index_reg_first;
    logic [ADDR_W-1:0] index_reg_second, next_addr, plant_addr;
    logic [WORD_W-1:0] operand_reg_tested;
    logic [HALF_W-1:0] plant_data;
    logic [21:0]       seen;
    int                fails, n_compared;
    cbu_issue_model u_model (.ref_clk(ref_clk), .issue_vld(issue_vld),
        .issue_op(issue_op), .issue_i(issue_i), .target_field(target_field),
        .cur_p(cur_p), .index_reg_first(index_reg_first),
        .index_reg_second(index_reg_second),
        .operand_reg_tested(operand_reg_tested));
    cbu_branch u_cbu_branch (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .clk_en(clk_en), .issue_vld(issue_vld), .issue_op(issue_op),
        .issue_i(issue_i), .target_field(target_field), .cur_p(cur_p),
        .index_reg_first(index_reg_first),
        .index_reg_second(index_reg_second),
        .operand_reg_tested(operand_reg_tested), .next_vld(next_vld),
        .next_addr(next_addr), .from_memory(from_memory),
        .stack_void(stack_void), .plant_we(plant_we),
        .plant_addr(plant_addr), .plant_data(plant_data));
    always #12.5 ref_clk = ~ref_clk;
    task automatic check(input string what, input logic [WORD_W-1:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Sends one instruction and samples the outputs of the answer cycle.
    task automatic issue(input logic [OP_W-1:0] op, input logic [2:0] i,
                         input logic [ADDR_W-1:0] k, p, bi, bj,
                         input logic [WORD_W-1:0] x, input logic z);
        u_model.send(op, i, k, p, bi, bj, x, z);
        u_model.idle();
        seen = {next_vld, stack_void, from_memory, plant_we, next_addr};
    endtask
    function automatic logic [21:0] dec(input logic t,
                                        input logic [17:0] k, p);
        return {4'h8, t ? k : p + 18'h00001};
    endfunction
    function automatic logic wtest(input logic [2:0] c, input logic [59:0] x);
        logic r;
        case (c[2:1])
            2'h0: r = (x == '0) || (&x);
            2'h1: r = !x[59];
            2'h2: r = !(x[59:48] == 12'h7ff || x[59:48] == 12'h800);
            default: r = !(x[59:48] == 12'h3ff || x[59:48] == 12'hc00);
        endcase
        return c[0] ? !r : r;
    endfunction
    function automatic logic ctest(input logic [1:0] c,
                                   input logic [17:0] a, b);
        logic ge;
        ge = (a[17] != b[17]) ? !a[17] : ($signed(a) >= $signed(b));
        case (c)
            2'h0: return a == b;
            2'h1: return a != b;
            2'h2: return ge;
            default: return !ge;
        endcase
    endfunction
    task automatic t_call();
        logic [47:0] pe = {18'h00100, 12'h100, 18'h00051};
        issue(OP_CALL_LINK, 3'h0, 18'h00100, 18'h00050, 0, 0, 0, 0);
        check("call", seen, {4'hf, 18'h00101});
        check("plant", {plant_addr, plant_data}, pe);
    endtask
    task automatic t_index();
        logic [17:0] bi [4] = '{18'h00005, 18'h00000, 18'h3fffe, 18'h3ffff};
        logic [17:0] ex [4] = '{18'h00105, 18'h00100, 18'h000ff, 18'h00100};
        for (int n = 0; n < 4; n++) begin
            issue(OP_IDX_JUMP, 3'h0, 18'h00100, 18'h00050, bi[n], 0, 0, 0);
            check("index", seen, {4'he, ex[n]});
        end
    endtask
    task automatic t_word();
        logic [59:0] xs [9] = '{60'h0, '1, 60'h1, 60'h800000000000001,
            {12'h7ff, 48'h1}, {12'h800, 48'h0}, {12'h3ff, 48'h5},
            {12'hc00, 48'h0}, {12'h400, 48'h0}};
        logic [21:0] want;
        for (int c = 0; c < 8; c++) begin
            for (int n = 0; n < 9; n++) begin
                want = dec(wtest(c[2:0], xs[n]), 18'h00200, 18'h00070);
                issue(OP_WORD_TEST, c[2:0], 18'h00200, 18'h00070, 0, 0,
                      xs[n], 0);
                check("word", seen, want);
            end
        end
    endtask
    task automatic t_cmp();
        logic [17:0] a [6] = '{18'h0, 18'h5, 18'h3, 18'h7, 18'h1, 18'h3fff0};
        logic [17:0] b [6] = '{18'h3ffff, 18'h5, 18'h7, 18'h3, 18'h3fff0,
            18'h3ff00};
        logic [5:0]  op;
        logic [21:0] want;
        for (int c = 0; c < 4; c++) begin
            op = OP_SAME + c[5:0];
            for (int n = 0; n < 6; n++) begin
                want = dec(ctest(c[1:0], a[n], b[n]), 18'h00300, 18'h00090);
                issue(op, 0, 18'h00300, 18'h00090, a[n], b[n], 0, 0);
                check("cmp", seen, want);
            end
            want = dec(ctest(c[1:0], 18'h3fffa, 0), 18'h00300, 18'h00090);
            issue(op, 0, 18'h00300, 18'h00090, 18'h3fffa, 18'h5, 0, 1);
            check("cmp_zero", seen, want);
        end
    endtask
    task automatic t_refuse_freeze();
        issue(6'h00, 0, 18'h00400, 18'h00010, 0, 0, 0, 0);
        check("refused", seen[21:18], 4'h0);
        issue(6'h3f, 0, 18'h00400, 18'h00010, 0, 0, 0, 0);
        check("refused", seen[21:18], 4'h0);
        @(negedge ref_clk) clk_en = 1'b0;
        issue(OP_CALL_LINK, 0, 18'h00400, 18'h00010, 0, 0, 0, 0);
        check("frozen", seen[21:18], 4'h0);
        @(negedge ref_clk) clk_en = 1'b1;
    endtask
    task automatic t_b2b();
        u_model.send(OP_CALL_LINK, 0, 18'h00500, 18'h00020, 0, 0, 0, 0);
        u_model.send(OP_SAME, 0, 18'h00600, 18'h00030, 18'h00009, 18'h00009,
                     0, 0);
        check("b2b_call", {next_vld, stack_void, next_addr}, 20'hc0501);
        u_model.idle();
        check("b2b_cmp", {next_vld, stack_void, next_addr}, 20'h80600);
    endtask
    // Mid-run reset clears every output; a call right after release works.
    task automatic t_reset();
        @(negedge ref_clk) sys_rst = 1'b1;
        @(negedge ref_clk);
        seen = {next_vld, stack_void, from_memory, plant_we, next_addr};
        check("rst_ctl", seen, 0);
        check("rst_plant", {plant_addr, plant_data}, 0);
        @(negedge ref_clk) sys_rst = 1'b0;
        t_call();
    endtask
    initial begin
        #(25 * 20000);
        fails++;
        summarize();
    end
    initial begin
        ref_clk = 1'b0;
        sys_rst = 1'b1;
        clk_en = 1'b1;
        fails = 0;
        n_compared = 0;
        repeat (12) @(negedge ref_clk);
        sys_rst = 1'b0;
        t_call();
        t_index();
        t_word();
        t_cmp();
        t_refuse_freeze();
        t_b2b();
        t_reset();
        summarize();
    end
endmodule
`default_nettype wire
